/* rtl/supply_fault_supervisor.v */
// Function
// - logic-supply undervoltage watched in init, restart, normal; acts after full filter.
// - logic-supply undervoltage suspends regulator short diagnosis until supply recovers.
// - logic-supply undervoltage sets sticky flag, cleared only by status clear.
// - in stop mode, logic undervoltage watched only on peak load or warning.
// - overvoltage recovery with pump disabled keeps pump and bridge off.
// - recovery mode 0 restarts pump and amp; bridge waits for flag clear.
// - recovery mode 1 restarts all; bridge on once pump voltage is good.
// - mode 0 overvoltage recovery restarts pump only without pump undervoltage.
// - power undervoltage: discharge, stop pump and amp, set sticky flag.
// - power undervoltage recovery restarts pump and amp; bridge waits for clear.
// - power overvoltage watched in init, restart, normal or with pump enabled.
// - power overvoltage: discharge, stop pump and amp, set sticky flag.
// - regulator below prewarning sets only warning flag; none set in sleep.
// - regulator under reset threshold pulls reset low, enters restart, flags after.
// - hysteresis bit releases reset only above the highest rising threshold.
// - consecutive regulator undervoltages counted, paused in normal on low supply.
// - fourth consecutive regulator undervoltage enters fail-safe and sets flag.
// - counter cleared on fail-safe entry, flag clear and soft reset.
// - regulator overvoltage flags while regulator enabled; reaction 11 forces fail-safe.
// - regulator short detection only while logic supply above undervoltage threshold.
// - regulator short timeout sets flags, turns regulator off, enters fail-safe.
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "supply_fault_supervisor_defines.vh"
module supply_fault_supervisor #(
  parameter HB_N = 3,
  parameter CCP_CYC = 15,
  parameter FILT_W = 12,
  parameter SC_CYC = `SC_TIME_CYC
) (
  input wire i_sys_clk,
  input wire i_reset,
  // avalon-mm slave
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  output reg [1:0] o_avs_response,
  // comparator inputs
  input wire i_logic_supply_uv,
  input wire i_logic_supply_ov,
  input wire i_power_supply_uv,
  input wire i_power_supply_ov,
  input wire i_regulator_warn,
  input wire i_regulator_below_reset,
  input wire i_regulator_above_top,
  input wire i_regulator_ov,
  input wire i_load_peak_threshold,
  input wire i_pump_voltage_ok,
  input wire i_charge_pump_under_flag,
  input wire [2*HB_N-1:0] i_half_bridge_mode,
  input wire [2:0] i_mode,
  input wire i_soft_reset,
  input wire i_reset_released,
  // actuator outputs
  output reg o_reset_output_n,
  output reg o_charge_pump_on,
  output reg o_passive_discharge,
  output reg o_sense_amp_on,
  output reg o_bridge_enable,
  output reg [HB_N-1:0] o_active_discharge,
  output reg o_regulator_on,
  output reg o_fail_output,
  output reg o_req_restart,
  output reg o_req_failsafe,
  output reg [1:0] o_regulator_over_event
);

////////////////////////////////////////////////////////////////////////
// comparator sync and filters
localparam NCMP = 4;
wire [NCMP-1:0] cmp_raw;
wire [NCMP-1:0] cmp_en;
wire [NCMP-1:0] cmp_filt;
reg [NCMP-1:0] sync1_ff;
reg [NCMP-1:0] sync2_ff;
wire in_active_mode;
reg [7:0] ctrl_ff;
reg [`ST_W-1:0] status_ff;

assign in_active_mode = (i_mode == `MODE_INIT) ||
  (i_mode == `MODE_RESTART) || (i_mode == `MODE_NORMAL);
assign cmp_raw = {i_power_supply_ov, i_power_supply_uv,
  i_logic_supply_ov, i_logic_supply_uv};
// stop mode saves current, so logic undervoltage watch needs a reason
assign cmp_en[0] = in_active_mode || ((i_mode == `MODE_STOP) &&
  (i_load_peak_threshold || i_regulator_warn));
assign cmp_en[1] = in_active_mode;
assign cmp_en[2] = in_active_mode;
assign cmp_en[3] = in_active_mode || ctrl_ff[`CTRL_CP_EN];

// two-flop synchroniser, first stage read only by second
always @(posedge i_sys_clk) begin
  if (i_reset) begin
    sync1_ff <= 4'h0;
    sync2_ff <= 4'h0;
  end else begin
    sync1_ff <= cmp_raw;
    sync2_ff <= sync1_ff;
  end
end

genvar g;
generate
  for (g = 0; g < NCMP; g = g + 1) begin : g_filt
    localparam [FILT_W-1:0] LIM = (g == 1 || g == 3) ?
      `OV_FILT_CYC : `UV_FILT_CYC;
    reg [FILT_W-1:0] cnt_ff;
    // counter restarts whenever comparator drops or watch is off
    always @(posedge i_sys_clk) begin
      if (i_reset || !sync2_ff[g] || !cmp_en[g]) begin
        cnt_ff <= {FILT_W{1'b0}};
      end else if (cnt_ff != LIM) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
    assign cmp_filt[g] = (cnt_ff == LIM);
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// bridge shutdown sequence
localparam SEQ_IDLE = 2'h0;
localparam SEQ_DISCH = 2'h1;
localparam SEQ_OFF = 2'h2;
reg [1:0] seq_ff;
reg [1:0] nxt_seq;
reg [7:0] ccp_cnt_ff;
reg [HB_N-1:0] hb_active;
wire fault_any;
wire fault_rise;
reg fault_d_ff;
wire ov_any;
wire ls_ov_fault, ps_uv_fault, ps_ov_fault;
reg was_ov_ff;

assign ls_ov_fault = cmp_filt[1];
assign ps_uv_fault = cmp_filt[2];
assign ps_ov_fault = cmp_filt[3];
assign ov_any = ls_ov_fault || ps_ov_fault;
assign fault_any = ov_any || ps_uv_fault;
assign fault_rise = fault_any && !fault_d_ff;

integer k;
always @* begin
  for (k = 0; k < HB_N; k = k + 1) begin
    hb_active[k] = i_half_bridge_mode[2*k] ^ i_half_bridge_mode[2*k+1];
  end
end

// next state of shutdown sequence
always @* begin
  nxt_seq = seq_ff;
  case (seq_ff)
    SEQ_IDLE: begin
      if (fault_rise) begin
        nxt_seq = SEQ_DISCH;
      end
    end
    SEQ_DISCH: begin
      if (ccp_cnt_ff == CCP_CYC[7:0]) begin
        nxt_seq = SEQ_OFF;
      end
    end
    SEQ_OFF: begin
      if (!fault_any) begin
        nxt_seq = SEQ_IDLE;
      end
    end
    default: nxt_seq = SEQ_IDLE;
  endcase
end

always @(posedge i_sys_clk) begin
  if (i_reset) begin
    seq_ff <= SEQ_IDLE;
    ccp_cnt_ff <= 8'h00;
    fault_d_ff <= 1'b0;
    was_ov_ff <= 1'b0;
  end else begin
    seq_ff <= nxt_seq;
    fault_d_ff <= fault_any;
    if (seq_ff == SEQ_DISCH) begin
      ccp_cnt_ff <= ccp_cnt_ff + 8'h01;
    end else begin
      ccp_cnt_ff <= 8'h00;
    end
    if (seq_ff == SEQ_IDLE && fault_rise) begin
      was_ov_ff <= ov_any;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// recovery and actuator control
wire ov_flags;
wire bridge_allow;
wire pump_allow;
wire csa_allow;
assign ov_flags = status_ff[`ST_LS_OV] || status_ff[`ST_PS_OV];
// pump restarts only when enabled, mode 0 after overvoltage also needs no pump undervoltage flag
assign pump_allow = ctrl_ff[`CTRL_CP_EN] && (ctrl_ff[`CTRL_OV_REC] ||
  !was_ov_ff || !i_charge_pump_under_flag);
assign csa_allow = ctrl_ff[`CTRL_CP_EN] && !ctrl_ff[`CTRL_SENSE_AMP_DISABLE];
// mode 1 ignores overvoltage flags once pump voltage is good
assign bridge_allow = ctrl_ff[`CTRL_CP_EN] && i_pump_voltage_ok &&
  !status_ff[`ST_PS_UV] &&
  (ctrl_ff[`CTRL_OV_REC] || !ov_flags);

always @(posedge i_sys_clk) begin
  if (i_reset) begin
    o_active_discharge <= {HB_N{1'b0}};
    o_charge_pump_on <= 1'b0;
    o_passive_discharge <= 1'b1;
    o_sense_amp_on <= 1'b0;
    o_bridge_enable <= 1'b0;
  end else begin
    if (seq_ff == SEQ_DISCH) begin
      o_active_discharge <= hb_active;
    end else begin
      o_active_discharge <= {HB_N{1'b0}};
    end
    if (seq_ff != SEQ_IDLE || fault_rise) begin
      o_bridge_enable <= 1'b0;
      if (seq_ff == SEQ_OFF) begin
        o_charge_pump_on <= 1'b0;
        o_passive_discharge <= 1'b1;
        if (ps_uv_fault || ps_ov_fault) begin
          o_sense_amp_on <= 1'b0;
        end
      end
    end else begin
      o_charge_pump_on <= pump_allow;
      o_passive_discharge <= !pump_allow;
      o_sense_amp_on <= csa_allow;
      o_bridge_enable <= bridge_allow;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// regulator supervision: reset, counter, overvoltage, short circuit
localparam [31:0] SC_W = SC_CYC;
reg under_ff;
reg [2:0] rep_cnt_ff;
reg [22:0] sc_cnt_ff;
reg pend_uv_ff;
reg reg_ov_d_ff;
wire reg_ok;
wire sc_enable;
wire in_sleep;
wire uv_fs_hit;
wire sc_hit;
wire ov_fs_hit;
wire [`ST_W-1:0] set_vec;
wire [`ST_W-1:0] clr_vec;
wire st_wr;
wire uv_flag_clear;
wire count_active;

assign in_sleep = (i_mode == `MODE_SLEEP);
// hysteresis bit holds reset until top rising threshold
assign reg_ok = ctrl_ff[`CTRL_RST_HYS] ?
  i_regulator_above_top : !i_regulator_below_reset;
// short diagnosis suspended while logic undervoltage is filtered
assign sc_enable = ctrl_ff[`CTRL_VREG_EN] && !cmp_filt[0];
assign sc_hit = sc_enable && !reg_ok &&
  (sc_cnt_ff == SC_W[22:0]);
assign count_active = (i_mode == `MODE_INIT) ||
  (i_mode == `MODE_STOP) ||
  ((i_mode == `MODE_NORMAL) && !sync2_ff[2]);
assign uv_fs_hit = !reg_ok && !under_ff && count_active &&
  ctrl_ff[`CTRL_VREG_EN] && (rep_cnt_ff == `REP_UV_LIMIT - 3'h1);
assign ov_fs_hit = ctrl_ff[`CTRL_VREG_EN] && i_regulator_ov &&
  !reg_ov_d_ff && (ctrl_ff[5:4] == `OV_REACT_FS);
assign st_wr = i_avs_write && (i_avs_address == `ADDR_STATUS);
assign clr_vec = st_wr ? i_avs_writedata[`ST_W-1:0] : {`ST_W{1'b0}};
assign uv_flag_clear = clr_vec[`ST_REG_UV];

assign set_vec[`ST_LS_UV] = cmp_filt[0];
assign set_vec[`ST_LS_OV] = ls_ov_fault && seq_ff == SEQ_OFF;
assign set_vec[`ST_PS_UV] = ps_uv_fault && seq_ff == SEQ_OFF;
assign set_vec[`ST_PS_OV] = ps_ov_fault && seq_ff == SEQ_OFF;
assign set_vec[`ST_REG_WARN] = ctrl_ff[`CTRL_VREG_EN] && !in_sleep &&
  i_regulator_warn;
assign set_vec[`ST_REG_UV] = pend_uv_ff && i_reset_released && reg_ok &&
  !in_sleep;
assign set_vec[`ST_REG_OV] = ctrl_ff[`CTRL_VREG_EN] && i_regulator_ov &&
  !reg_ov_d_ff;
assign set_vec[`ST_REG_SC] = sc_hit;
assign set_vec[`ST_REP_UV_FS] = uv_fs_hit;
assign set_vec[`ST_FAILURE] = sc_hit;

// sticky flags, hardware set wins over a same-cycle clear
always @(posedge i_sys_clk) begin
  if (i_reset) begin
    status_ff <= {`ST_W{1'b0}};
  end else begin
    status_ff <= (status_ff & ~clr_vec) | set_vec;
  end
end

always @(posedge i_sys_clk) begin
  if (i_reset) begin
    o_reset_output_n <= 1'b0;
    under_ff <= 1'b0;
    rep_cnt_ff <= 3'h0;
    sc_cnt_ff <= 23'h0;
    pend_uv_ff <= 1'b0;
    reg_ov_d_ff <= 1'b0;
    o_regulator_on <= 1'b1;
    o_fail_output <= 1'b0;
    o_req_restart <= 1'b0;
    o_req_failsafe <= 1'b0;
    o_regulator_over_event <= 2'h0;
  end else begin
    reg_ov_d_ff <= i_regulator_ov;
    o_req_restart <= 1'b0;
    o_req_failsafe <= uv_fs_hit || sc_hit || ov_fs_hit;
    if (ctrl_ff[`CTRL_VREG_EN] && i_regulator_ov && !reg_ov_d_ff) begin
      o_regulator_over_event <= ctrl_ff[5:4];
    end
    // reset output follows regulator threshold with chosen hysteresis
    if (ctrl_ff[`CTRL_VREG_EN] && !in_sleep && i_regulator_below_reset &&
        o_reset_output_n) begin
      o_reset_output_n <= 1'b0;
      o_req_restart <= 1'b1;
      pend_uv_ff <= 1'b1;
    end else if (!o_reset_output_n && reg_ok && i_reset_released) begin
      o_reset_output_n <= 1'b1;
    end
    if (set_vec[`ST_REG_UV]) begin
      pend_uv_ff <= 1'b0;
    end
    // event counter, one count per falling crossing
    under_ff <= !reg_ok;
    if (uv_fs_hit || sc_hit || ov_fs_hit || uv_flag_clear ||
        i_soft_reset) begin
      rep_cnt_ff <= 3'h0;
    end else if (!reg_ok && !under_ff && count_active &&
        ctrl_ff[`CTRL_VREG_EN]) begin
      rep_cnt_ff <= rep_cnt_ff + 3'h1;
    end
    // short circuit timer counts while regulator stays below threshold
    if (!sc_enable || reg_ok) begin
      sc_cnt_ff <= 23'h0;
    end else if (sc_cnt_ff != SC_W[22:0]) begin
      sc_cnt_ff <= sc_cnt_ff + 23'h1;
    end
    if (sc_hit) begin
      o_regulator_on <= 1'b0;
      o_fail_output <= 1'b1;
    end else if (ctrl_ff[`CTRL_VREG_EN] && !o_regulator_on &&
        i_mode != `MODE_FAILSAFE) begin
      o_regulator_on <= 1'b1; // wake-up restarts the regulator
      o_fail_output <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// avalon-mm slave: writes take no wait, reads one to load the data flops
reg rd_ack_ff;
assign o_avs_waitrequest = i_avs_read && !rd_ack_ff;

// control register, byte-lane qualified
always @(posedge i_sys_clk) begin
  if (i_reset) begin
    ctrl_ff <= `CTRL_RESET;
  end else if (i_avs_write && i_avs_address == `ADDR_CTRL &&
      i_avs_byteenable[0]) begin
    ctrl_ff <= i_avs_writedata[7:0];
  end
end

// read data loaded in the wait cycle, standing at the accepting edge
always @(posedge i_sys_clk) begin
  rd_ack_ff <= i_avs_read && !rd_ack_ff && !i_reset;
  o_avs_response <= 2'h0;
  case (i_avs_address)
    `ADDR_CTRL: o_avs_readdata <= {24'h0, ctrl_ff};
    `ADDR_STATUS: o_avs_readdata <= {{(32-`ST_W){1'b0}}, status_ff};
    `ADDR_STATE: o_avs_readdata <= {20'h0, rep_cnt_ff, seq_ff,
      o_reset_output_n, o_regulator_on, o_bridge_enable,
      o_charge_pump_on, o_sense_amp_on, o_fail_output, o_passive_discharge};
    default: begin
      o_avs_readdata <= 32'h0;
      o_avs_response <= i_avs_read ? 2'h2 : 2'h0;
    end
  endcase
end

endmodule // supply_fault_supervisor
`default_nettype wire

/* rtl/supply_fault_supervisor_defines.vh */
`ifndef SUPPLY_FAULT_SUPERVISOR_DEFINES_VH
`define SUPPLY_FAULT_SUPERVISOR_DEFINES_VH
// register offsets (byte addresses, one word each)
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_STATE 4'h8
// control register fields
`define CTRL_CP_EN 0
`define CTRL_OV_REC 1
`define CTRL_SENSE_AMP_DISABLE 2
`define CTRL_RST_HYS 3
`define CTRL_OV_REACT_LO 4
`define CTRL_VREG_EN 6
`define CTRL_RESET 8'h41
// status register fields (write one to clear)
`define ST_LS_UV 0
`define ST_LS_OV 1
`define ST_PS_UV 2
`define ST_PS_OV 3
`define ST_REG_WARN 4
`define ST_REG_UV 5
`define ST_REG_OV 6
`define ST_REG_SC 7
`define ST_REP_UV_FS 8
`define ST_FAILURE 9
`define ST_W 10
// device modes
`define MODE_INIT 3'h0
`define MODE_NORMAL 3'h1
`define MODE_STOP 3'h2
`define MODE_SLEEP 3'h3
`define MODE_RESTART 3'h4
`define MODE_FAILSAFE 3'h5
// timing in microseconds, clock in MHz
`define CLK_MHZ 25
`define UV_FILT_US 10
`define OV_FILT_US 10
`define SC_TIME_US 2000
`define UV_FILT_CYC (`UV_FILT_US * `CLK_MHZ)
`define OV_FILT_CYC (`OV_FILT_US * `CLK_MHZ)
`define SC_TIME_CYC (`SC_TIME_US * `CLK_MHZ)
`define REP_UV_LIMIT 3'h4
`define OV_REACT_FS 2'h3
`endif

/* testbench/supply_fault_checker_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
`include "supply_fault_supervisor_defines.vh"
module supply_fault_checker #(
  parameter HB_N = 3
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_logic_supply_ov,
  input wire logic i_power_supply_uv,
  input wire logic i_power_supply_ov,
  input wire logic i_regulator_below_reset,
  input wire logic i_regulator_ov,
  input wire logic i_reset_released,
  input wire logic o_reset_output_n,
  input wire logic o_charge_pump_on,
  input wire logic o_passive_discharge,
  input wire logic o_bridge_enable,
  input wire logic [HB_N-1:0] o_active_discharge,
  input wire logic o_regulator_on,
  input wire logic o_fail_output,
  input wire logic [1:0] o_regulator_over_event
);
  localparam int FILT = `UV_FILT_CYC;
  logic [11:0] run_ff;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // length of the current unbroken supply fault; any gap restarts it
  always @(posedge i_sys_clk) begin
    if (i_reset || !(i_logic_supply_ov | i_power_supply_uv | i_power_supply_ov))
      run_ff <= 12'h000;
    else if (run_ff != 12'hFFF)
      run_ff <= run_ff + 12'h001;
  end
  AST_FILTER: assert property (
    $rose(|o_active_discharge) |-> run_ff >= FILT)
    else $error("discharge began before the fault filter ran out");
  AST_DISCH_BRIDGE: assert property (
    (|o_active_discharge) |-> !o_bridge_enable)
    else $error("bridge enabled during active discharge");
  AST_DISCH_SEQ: assert property (
    $rose(|o_active_discharge) |-> (|o_active_discharge)[*8] ##[7:10]
    (!o_charge_pump_on && o_passive_discharge && o_active_discharge == '0))
    else $error("discharge did not end in pump off with passive discharge");
  AST_SHORT_OFF: assert property (
    $rose(o_fail_output) |-> ##[0:2] !o_regulator_on)
    else $error("fail output raised with regulator still on");
  AST_RST_REL: assert property (
    $rose(o_reset_output_n) |->
    $past(!i_regulator_below_reset && i_reset_released))
    else $error("reset released while regulator low");
  AST_RST_LOW: assert property (
    $rose(i_regulator_below_reset) |-> ##[1:400] !o_reset_output_n)
    else $error("reset not pulled low on regulator undervoltage");
  AST_OV_EVENT: assert property (
    $changed(o_regulator_over_event) |-> i_regulator_ov || $past(i_regulator_ov))
    else $error("over event changed without regulator overvoltage");
  AST_PUMP_BRIDGE: assert property (
    o_bridge_enable |-> o_charge_pump_on || $past(o_charge_pump_on))
    else $error("bridge enabled with charge pump off");
endmodule // supply_fault_checker
////////////////////////////////////////
bind supply_fault_supervisor supply_fault_checker #(.HB_N(HB_N)) u_chk (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_logic_supply_ov(i_logic_supply_ov), .i_power_supply_uv(i_power_supply_uv),
  .i_power_supply_ov(i_power_supply_ov),
  .i_regulator_below_reset(i_regulator_below_reset),
  .i_regulator_ov(i_regulator_ov), .i_reset_released(i_reset_released),
  .o_reset_output_n(o_reset_output_n), .o_charge_pump_on(o_charge_pump_on),
  .o_passive_discharge(o_passive_discharge), .o_bridge_enable(o_bridge_enable),
  .o_active_discharge(o_active_discharge), .o_regulator_on(o_regulator_on),
  .o_fail_output(o_fail_output),
  .o_regulator_over_event(o_regulator_over_event));
`default_nettype wire

/* testbench/pump_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pump_model #(
  parameter int RAMP = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_charge_pump_on,
  output logic o_pump_voltage_ok
);
  logic [3:0] ramp_ff;
  // the pump needs time to charge, so voltage good lags the enable
  always @(posedge i_sys_clk) begin
    if (!i_charge_pump_on)
      ramp_ff <= 4'h0;
    else if (ramp_ff != RAMP[3:0])
      ramp_ff <= ramp_ff + 4'h1;
  end
  assign o_pump_voltage_ok = (ramp_ff == RAMP[3:0]);
endmodule // pump_model
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "supply_fault_supervisor_defines.vh"
module tb;
  localparam int SC = 400;
  logic clk, rst, rd, wr, wq, ls_uv, ls_ov, ps_uv, ps_ov, warn, below;
  logic rov, rel, pok, rst_out_n, pump, pas, amp, brg, reg_on, fail;
  logic rq_rs, rq_fs, srst, top;
  logic [3:0] adr;
  logic [31:0] wd, rdat, v;
  logic [1:0] resp, rsp, oev;
  logic [5:0] hbm;
  logic [2:0] mode, ad;
  int mismatches, n_checks, fs_cnt, rs_cnt;
  ////////////////////////////////////////
  supply_fault_supervisor #(.SC_CYC(SC)) uut (
    .i_sys_clk(clk), .i_reset(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq), .o_avs_response(resp),
    .i_logic_supply_uv(ls_uv), .i_logic_supply_ov(ls_ov),
    .i_power_supply_uv(ps_uv), .i_power_supply_ov(ps_ov),
    .i_regulator_warn(warn), .i_regulator_below_reset(below),
    .i_regulator_above_top(top), .i_regulator_ov(rov),
    .i_load_peak_threshold(1'b0), .i_pump_voltage_ok(pok),
    .i_charge_pump_under_flag(1'b0), .i_half_bridge_mode(hbm),
    .i_mode(mode), .i_soft_reset(srst), .i_reset_released(rel),
    .o_reset_output_n(rst_out_n), .o_charge_pump_on(pump),
    .o_passive_discharge(pas), .o_sense_amp_on(amp),
    .o_bridge_enable(brg), .o_active_discharge(ad),
    .o_regulator_on(reg_on), .o_fail_output(fail),
    .o_req_restart(rq_rs), .o_req_failsafe(rq_fs),
    .o_regulator_over_event(oev));
  pump_model u_pump (.i_sys_clk(clk), .i_charge_pump_on(pump),
    .o_pump_voltage_ok(pok));
  // restart requests are one-cycle pulses, fail-safe stays high on a short, so tally every cycle
  always @(posedge clk) begin
    if (rq_fs === 1'b1)
      fs_cnt++;
    if (rq_rs === 1'b1)
      rs_cnt++;
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // hold the request until waitrequest is seen low at an edge
  // only the watchdog ends a wait that never finishes
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wq !== 1'b0)
      @(posedge clk);
    v = rdat;
    rsp = resp;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task st;
    bus(1'b0, `ADDR_STATUS, 32'h0);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_reset;
    chk("reset_n", 0, rst_out_n);
    bus(1'b0, `ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h41, v & 32'hFF);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped resp", 2, rsp);
    chk("unmapped data", 0, v);
    rel <= 1'b1;
    step(20);
    chk("reset_n released", 1, rst_out_n);
    $display("test reset done");
  endtask
  task t_puv;
    chk("bridge", 1, brg);
    ps_uv <= 1'b1;
    step(`UV_FILT_CYC - 10);
    ps_uv <= 1'b0;
    step(5);
    st();
    chk("ps_uv glitch", 0, v[`ST_PS_UV]);
    ps_uv <= 1'b1;
    step(`UV_FILT_CYC + 8);
    chk("discharge", 3'b110, ad);
    step(20);
    chk("pump", 0, pump);
    chk("passive", 1, pas);
    chk("amp", 0, amp);
    st();
    chk("ps_uv", 1, v[`ST_PS_UV]);
    ps_uv <= 1'b0;
    step(20);
    chk("pump back", 1, pump);
    chk("amp back", 1, amp);
    chk("bridge held", 0, brg);
    bus(1'b1, `ADDR_STATUS, 32'h4);
    step(20);
    chk("bridge back", 1, brg);
    $display("test power undervoltage done");
  endtask
  // recovery mode m decides whether the bridge waits for the flag
  task t_lsov(input logic m);
    bus(1'b1, `ADDR_CTRL, 32'h41 | {m, 1'b0});
    ls_ov <= 1'b1;
    step(`OV_FILT_CYC + 8);
    chk("ls_ov discharge", 3'b110, ad);
    step(20);
    chk("ls_ov pump", 0, pump);
    ls_ov <= 1'b0;
    step(20);
    chk("rec pump", 1, pump);
    chk("rec bridge", m, brg);
    st();
    chk("ls_ov flag", 1, v[`ST_LS_OV]);
    bus(1'b1, `ADDR_STATUS, 32'h2);
    step(20);
    chk("bridge after clear", 1, brg);
    $display("test logic overvoltage done");
  endtask
  task t_cpoff;
    bus(1'b1, `ADDR_CTRL, 32'h40);
    ps_ov <= 1'b1;
    step(`OV_FILT_CYC + 30);
    st();
    chk("ps_ov", 1, v[`ST_PS_OV]);
    ps_ov <= 1'b0;
    // let the filter drop first, or the still-set fault wins the clear
    step(5);
    bus(1'b1, `ADDR_STATUS, 32'h8);
    step(20);
    chk("pump off", 0, pump);
    chk("bridge off", 0, brg);
    bus(1'b1, `ADDR_CTRL, 32'h41);
    step(20);
    $display("test pump disabled done");
  endtask
  task t_lsuv;
    ls_uv <= 1'b1;
    warn <= 1'b1;
    step(`UV_FILT_CYC + 8);
    ls_uv <= 1'b0;
    warn <= 1'b0;
    step(5);
    st();
    chk("sticky flags", 32'h11, v & 32'h11);
    bus(1'b1, `ADDR_STATUS, 32'h11);
    st();
    chk("flags cleared", 0, v & 32'h11);
    $display("test logic undervoltage done");
  endtask
  // only the fourth dip in a row may ask for fail-safe
  task t_reguv;
    for (int i = 1; i <= 4; i++) begin
      below <= 1'b1;
      rel <= 1'b0;
      step(300);
      chk("reset_n low", 0, rst_out_n);
      below <= 1'b0;
      step(5);
      rel <= 1'b1;
      step(20);
      chk("restart req", i, rs_cnt);
      chk("failsafe req", i == 4, fs_cnt);
    end
    st();
    chk("uv flags", 32'h120, v & 32'h120);
    $display("test regulator undervoltage done");
  endtask
  task t_regov;
    int c;
    for (int s = 0; s < 4; s++) begin
      c = fs_cnt;
      bus(1'b1, `ADDR_CTRL, 32'h41 | (s << 4));
      rov <= 1'b1;
      step(300);
      rov <= 1'b0;
      st();
      chk("ov flag", 1, v[`ST_REG_OV]);
      chk("ov event", s, oev);
      chk("ov failsafe", s == 3, fs_cnt - c);
      bus(1'b1, `ADDR_STATUS, 32'h40);
    end
    $display("test regulator overvoltage done");
  endtask
  // hysteresis holds reset until the top threshold; soft reset empties
  // the dip counter
  task t_cnt;
    top <= 1'b1;
    bus(1'b1, `ADDR_CTRL, 32'h49);
    below <= 1'b1;
    top <= 1'b0;
    step(5);
    below <= 1'b0;
    step(20);
    chk("hys reset_n held", 0, rst_out_n);
    top <= 1'b1;
    step(5);
    chk("hys reset_n", 1, rst_out_n);
    bus(1'b0, `ADDR_STATE, 32'h0);
    chk("uv count", 1, v[11:9]);
    srst <= 1'b1;
    step(1);
    srst <= 1'b0;
    bus(1'b0, `ADDR_STATE, 32'h0);
    chk("count after soft reset", 0, v[11:9]);
    bus(1'b1, `ADDR_CTRL, 32'h41);
    $display("test counter and hysteresis done");
  endtask
  task t_short;
    int c;
    c = fs_cnt;
    below <= 1'b1;
    step(SC + 300);
    chk("regulator off", 0, reg_on);
    chk("fail output", 1, fail);
    chk("short failsafe", 1, fs_cnt > c);
    st();
    chk("short flags", 32'h280, v & 32'h280);
    $display("test regulator short done");
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {rd, wr, ls_uv, ls_ov, ps_uv, ps_ov, warn, below, rov, rel} = '0;
    {srst, top} = 2'b00;
    adr = 4'h0;
    wd = 32'h0;
    hbm = 6'h18;
    mode = `MODE_NORMAL;
    step(12);
    rst <= 1'b0;
    step(2);
    t_reset();
    t_puv();
    t_lsov(1'b0);
    t_lsov(1'b1);
    t_cpoff();
    t_lsuv();
    t_reguv();
    t_regov();
    t_cnt();
    t_short();
    end_sim();
  end
  // a hang cuts the run short well past the expected length
  initial begin
    step(20000);
    mismatches++;
    $display("Error watchdog expected done seen hang");
    end_sim();
  end
endmodule // tb
`default_nettype wire
